// ===== pfp_pkg.sv
// Package with constants and types for the program flash protection block.
//------------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------------
`default_nettype none
package pfp_pkg;
	// Memory map.
	localparam logic [15:0] PFP_USER_TOP    = 16'hf800;
	localparam logic [15:0] PFP_UPDATE_TOP  = 16'he000;
	localparam logic [15:0] PFP_BOOT_VECTOR = 16'he000;
	localparam logic [15:0] PFP_RESET_VECTOR = 16'h0000;
	localparam logic [15:0] PFP_DATA_TOP    = 16'h1000;
	// Register offsets.
	localparam logic [7:0] PFP_CTRL_OFS   = 8'h00;
	localparam logic [7:0] PFP_STATUS_OFS = 8'h04;
	localparam logic [7:0] PFP_REJECT_OFS = 8'h08;
	// Field positions.
	localparam int PFP_CTRL_UPDATE    = 0;
	localparam int PFP_STAT_UPDATE    = 0;
	localparam int PFP_STAT_LOCK      = 1;
	localparam int PFP_STAT_SECURE    = 2;
	localparam int PFP_STAT_SAFE      = 3;
	localparam int PFP_STAT_BOOT      = 4;
	localparam int PFP_STAT_DOWNLOAD  = 5;
	// Reset values and the reject counter step.
	localparam logic [31:0] PFP_ZERO_WORD = 32'h0000_0000;
	localparam logic [15:0] PFP_REJECT_RST = 16'h0000;
	localparam logic [15:0] PFP_REJECT_ONE = 16'h0001;
	// Cycles after reset release before the strobe level is trusted.
	localparam logic [1:0] PFP_SETTLE_CYCLES = 2'h2;

	typedef enum logic [1:0] {
		PFP_OP_ERASE = 2'h1,
		PFP_OP_WRITE = 2'h2
	} pfp_op_t;

	typedef enum logic [6:0] {
		PFP_CMD_PROGRAM    = 7'h01,
		PFP_CMD_READ       = 7'h02,
		PFP_CMD_CODE_ERASE = 7'h04,
		PFP_CMD_SET_LOCK   = 7'h08,
		PFP_CMD_SET_SECURE = 7'h10,
		PFP_CMD_SET_SAFE   = 7'h20,
		PFP_CMD_SET_BOOT   = 7'h40
	} pfp_cmd_t;

	typedef enum logic [2:0] {
		PFP_ST_SETTLE = 3'h1,
		PFP_ST_DECIDE = 3'h2,
		PFP_ST_RUN    = 3'h4
	} pfp_state_t;

	typedef struct packed {
		pfp_op_t     op;
		logic [15:0] addr;
	} pfp_user_req_t;

	typedef struct packed {
		logic        parallel;
		pfp_cmd_t    cmd;
		logic [15:0] addr;
	} pfp_prog_cmd_t;

	typedef struct packed {
		logic lock;
		logic secure;
		logic safe;
		logic boot;
	} pfp_opts_t;
endpackage
`default_nettype wire

// ===== pfp_opts.sv
// Nonvolatile security and boot option bits of the program flash protection.
`timescale 1ns/10ps
`default_nettype none
module pfp_opts
	import pfp_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire logic      clk_en,
	input  wire logic      cmd_valid,
	input  wire logic      cmd_parallel,
	input  wire pfp_cmd_t  cmd,
	output pfp_opts_t      opts
);
	pfp_opts_t store = '0;

	//--------------------------------------------------------------------------
	// Option bits.
	//--------------------------------------------------------------------------
	// The bits are nonvolatile, so a system reset leaves them as they are.
	assign opts = store;

	// Each bit has its own set command; erase clears lock and secure, safe only when parallel, and never boot.
	always_ff @(posedge pclk) begin
		if (presetn && clk_en && cmd_valid) begin
			case (cmd)
				PFP_CMD_SET_LOCK:   store.lock   <= 1'b1;
				PFP_CMD_SET_SECURE: store.secure <= 1'b1;
				PFP_CMD_SET_SAFE:   store.safe   <= 1'b1;
				PFP_CMD_SET_BOOT:   store.boot   <= 1'b1;
				PFP_CMD_CODE_ERASE: begin
					store.lock   <= 1'b0;
					store.secure <= 1'b0;
					if (cmd_parallel) begin
						store.safe <= 1'b0;
					end
				end
				default: store <= store;
			endcase
		end
	end
endmodule // pfp_opts
`default_nettype wire

// ===== pfp_top.sv
// Access control for the on-chip program flash, with APB status and control.
`timescale 1ns/10ps
`default_nettype none
module pfp_top
	import pfp_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          clk_en,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          user_valid,
	input  wire pfp_user_req_t user_req,
	output logic               user_grant,
	output logic               user_reject,
	input  wire logic          prog_valid,
	input  wire pfp_prog_cmd_t prog_cmd,
	output logic               prog_accept,
	output logic               prog_refuse,
	output logic               flash_go,
	output pfp_op_t            flash_op,
	output logic [15:0]        flash_addr,
	input  wire logic          code_read_instruction_valid,
	input  wire logic          code_read_external,
	output logic               code_read_allow,
	input  wire logic          data_valid,
	input  wire logic          data_external,
	input  wire logic [15:0]   data_addr,
	output logic               data_allow,
	input  wire logic          program_store_strobe_n,
	output logic               serial_download_mode,
	output logic               boot_ready,
	output logic [15:0]        boot_vector
);
	//--------------------------------------------------------------------------
	// Declarations.
	//--------------------------------------------------------------------------
	logic          user_update_mode;
	logic [15:0]   reject_count;
	logic          strobe_meta;
	logic          strobe_sync;
	logic [1:0]    settle_count;
	pfp_state_t    state;
	pfp_opts_t     opts;
	logic          user_ok;
	logic          prog_ok;
	logic          apb_write;
	logic          apb_read;
	logic [31:0]   next_prdata;
	logic          next_pslverr;

	//--------------------------------------------------------------------------
	// Address checks.
	//--------------------------------------------------------------------------
	// Tells whether user code may change the given program address.
	function automatic logic user_may_write(input logic        update,
	                                        input logic [15:0] addr);
		user_may_write = update && (addr < PFP_UPDATE_TOP);
	endfunction

	// Tells whether a programmer command passes the security modes.
	function automatic logic prog_allowed(input pfp_opts_t     o,
	                                      input pfp_prog_cmd_t c);
		prog_allowed = 1'b1;
		if (c.parallel && c.cmd == PFP_CMD_PROGRAM && (o.lock || o.secure)) begin
			prog_allowed = 1'b0;
		end
		if (c.parallel && c.cmd == PFP_CMD_READ && o.secure) begin
			prog_allowed = 1'b0;
		end
		if (c.cmd == PFP_CMD_PROGRAM && c.addr >= PFP_USER_TOP) begin
			prog_allowed = 1'b0;
		end
	endfunction

	assign user_ok = user_may_write(user_update_mode, user_req.addr);
	assign prog_ok = prog_allowed(opts, prog_cmd);

	//--------------------------------------------------------------------------
	// Option store.
	//--------------------------------------------------------------------------
	pfp_opts i_pfp_opts (
		.pclk         (pclk),
		.presetn      (presetn),
		.clk_en       (clk_en),
		.cmd_valid    (prog_valid && prog_ok),
		.cmd_parallel (prog_cmd.parallel),
		.cmd          (prog_cmd.cmd),
		.opts         (opts)
	);

	//--------------------------------------------------------------------------
	// User code erase and write requests.
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_grant  <= 1'b0;
			user_reject <= 1'b0;
		end else if (clk_en) begin
			user_grant  <= user_valid && user_ok;
			user_reject <= user_valid && !user_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_count <= PFP_REJECT_RST;
		end else if (clk_en && user_valid && !user_ok) begin
			reject_count <= reject_count + PFP_REJECT_ONE;
		end
	end

	//--------------------------------------------------------------------------
	// Programmer commands.
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_accept <= 1'b0;
			prog_refuse <= 1'b0;
		end else if (clk_en) begin
			prog_accept <= prog_valid && prog_ok;
			prog_refuse <= prog_valid && !prog_ok;
		end
	end

	//--------------------------------------------------------------------------
	// Flash operation port.
	//--------------------------------------------------------------------------
	// A programmer operation takes precedence over user code in one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_go   <= 1'b0;
			flash_op   <= PFP_OP_ERASE;
			flash_addr <= 16'h0000;
		end else if (clk_en) begin
			flash_go <= 1'b0;
			if (prog_valid && prog_ok && prog_cmd.cmd == PFP_CMD_PROGRAM) begin
				flash_go   <= 1'b1;
				flash_op   <= PFP_OP_WRITE;
				flash_addr <= prog_cmd.addr;
			end else if (prog_valid && prog_ok &&
			             prog_cmd.cmd == PFP_CMD_CODE_ERASE) begin
				flash_go   <= 1'b1;
				flash_op   <= PFP_OP_ERASE;
				flash_addr <= 16'h0000;
			end else if (user_valid && user_ok) begin
				flash_go   <= 1'b1;
				flash_op   <= user_req.op;
				flash_addr <= user_req.addr;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Read gating.
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_read_allow <= 1'b0;
			data_allow      <= 1'b0;
		end else if (clk_en) begin
			code_read_allow <= code_read_instruction_valid &&
			                   !(code_read_external && opts.secure);
			data_allow      <= data_valid && (data_addr < PFP_DATA_TOP) &&
			                   !(data_external && opts.secure);
		end
	end

	//--------------------------------------------------------------------------
	// Reset entry.
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_meta <= 1'b1;
			strobe_sync <= 1'b1;
		end else if (clk_en) begin
			strobe_meta <= program_store_strobe_n;
			strobe_sync <= strobe_meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= PFP_ST_SETTLE;
			settle_count         <= 2'h0;
			serial_download_mode <= 1'b0;
			boot_ready           <= 1'b0;
			boot_vector          <= PFP_RESET_VECTOR;
		end else if (clk_en) begin
			case (state)
				PFP_ST_SETTLE: begin
					settle_count <= settle_count + 2'h1;
					if (settle_count == PFP_SETTLE_CYCLES - 2'h1) begin
						state <= PFP_ST_DECIDE;
					end
				end
				PFP_ST_DECIDE: begin
					serial_download_mode <= !strobe_sync && !opts.safe;
					boot_vector <= opts.boot ? PFP_BOOT_VECTOR
					                         : PFP_RESET_VECTOR;
					boot_ready  <= 1'b1;
					state       <= PFP_ST_RUN;
				end
				PFP_ST_RUN: begin
					state <= PFP_ST_RUN;
				end
				default: begin
					state <= PFP_ST_SETTLE;
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// APB slave.
	//--------------------------------------------------------------------------
	assign pready    = 1'b1;
	assign apb_write = psel && penable && pwrite;
	assign apb_read  = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_update_mode <= 1'b0;
		end else if (clk_en && apb_write && paddr == PFP_CTRL_OFS) begin
			user_update_mode <= pwdata[PFP_CTRL_UPDATE];
		end
	end

	always_comb begin
		next_prdata  = PFP_ZERO_WORD;
		next_pslverr = 1'b0;
		case (paddr)
			PFP_CTRL_OFS: begin
				next_prdata[PFP_CTRL_UPDATE] = user_update_mode;
			end
			PFP_STATUS_OFS: begin
				next_prdata[PFP_STAT_UPDATE]   = user_update_mode;
				next_prdata[PFP_STAT_LOCK]     = opts.lock;
				next_prdata[PFP_STAT_SECURE]   = opts.secure;
				next_prdata[PFP_STAT_SAFE]     = opts.safe;
				next_prdata[PFP_STAT_BOOT]     = opts.boot;
				next_prdata[PFP_STAT_DOWNLOAD] = serial_download_mode;
			end
			PFP_REJECT_OFS: begin
				next_prdata[15:0] = reject_count;
			end
			default: begin
				next_pslverr = 1'b1;
			end
		endcase
	end

	// Read data is captured in the setup cycle and held through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= PFP_ZERO_WORD;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (apb_read) begin
				prdata <= next_prdata;
			end
			if (psel && !penable) begin
				pslverr <= next_pslverr;
			end
		end
	end
endmodule // pfp_top
`default_nettype wire

// ===== pfp_asserts.sv
// Port checker for the program flash protection block.
`timescale 1ns/10ps
`default_nettype none
module pfp_asserts
	import pfp_pkg::*;
(
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          clk_en,
	input wire logic          user_valid,
	input wire pfp_user_req_t user_req,
	input wire logic          user_grant,
	input wire logic          user_reject,
	input wire logic          prog_valid,
	input wire pfp_prog_cmd_t prog_cmd,
	input wire logic          prog_accept,
	input wire logic          prog_refuse,
	input wire logic          flash_go,
	input wire logic          code_read_instruction_valid,
	input wire logic          code_read_external,
	input wire logic          code_read_allow,
	input wire logic          serial_download_mode,
	input wire logic          boot_ready,
	input wire logic [15:0]   boot_vector
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_top_ro;
		user_valid && clk_en && user_req.addr >= PFP_UPDATE_TOP
		|=> user_reject && !user_grant;
	endproperty
	a_top_ro: assert property (p_top_ro)
		else $error("user write to upper region not rejected");
	property p_pulse;
		user_grant || user_reject
		|-> $past(user_valid && clk_en) && !(user_grant && user_reject);
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("user answer without request");
	property p_rej;
		user_reject && !$past(prog_valid) |-> !flash_go;
	endproperty
	a_rej: assert property (p_rej)
		else $error("flash started on rejected request");
	property p_prog_top;
		prog_valid && clk_en && prog_cmd.cmd == PFP_CMD_PROGRAM
		&& prog_cmd.addr >= PFP_USER_TOP |=> prog_refuse;
	endproperty
	a_prog_top: assert property (p_prog_top)
		else $error("program beyond memory accepted");
	property p_prog_ans;
		prog_valid && clk_en |=> prog_accept != prog_refuse;
	endproperty
	a_prog_ans: assert property (p_prog_ans)
		else $error("programmer command not answered once");
	property p_code_int;
		code_read_instruction_valid && !code_read_external && clk_en
		|=> code_read_allow;
	endproperty
	a_code_int: assert property (p_code_int)
		else $error("internal code read blocked");
	property p_boot;
		$rose(boot_ready)
		|-> boot_vector == PFP_BOOT_VECTOR || boot_vector == PFP_RESET_VECTOR;
	endproperty
	a_boot: assert property (p_boot)
		else $error("bad start address");
	property p_sdm;
		boot_ready && $past(boot_ready) |-> $stable(serial_download_mode);
	endproperty
	a_sdm: assert property (p_sdm)
		else $error("download mode changed after start");
	c_grant: cover property (user_grant);
	c_refuse: cover property (prog_refuse);
	c_sdm: cover property (serial_download_mode && boot_ready);
endmodule // pfp_asserts
bind pfp_top pfp_asserts i_pfp_asserts (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .user_valid(user_valid), .user_req(user_req),
	.user_grant(user_grant), .user_reject(user_reject),
	.prog_valid(prog_valid), .prog_cmd(prog_cmd),
	.prog_accept(prog_accept), .prog_refuse(prog_refuse),
	.flash_go(flash_go),
	.code_read_instruction_valid(code_read_instruction_valid),
	.code_read_external(code_read_external),
	.code_read_allow(code_read_allow),
	.serial_download_mode(serial_download_mode),
	.boot_ready(boot_ready), .boot_vector(boot_vector));
`default_nettype wire

// ===== pfp_prog_model.sv
// Model of the external serial downloader and parallel programmer.
`timescale 1ns/10ps
`default_nettype none
module pfp_prog_model
	import pfp_pkg::*;
(
	input  wire logic     pclk,
	output logic          prog_valid,
	output pfp_prog_cmd_t prog_cmd
);
	initial begin
		prog_valid = 1'b0;
		prog_cmd = '0;
	end
	// Serial commands are driven after three clocks, parallel ones after one clock.
	task send(input logic p, input pfp_cmd_t c, input logic [15:0] a);
		repeat (p ? 1 : 3) @(posedge pclk);
		prog_valid <= 1'b1;
		prog_cmd <= '{p, c, a};
		@(posedge pclk);
		prog_valid <= 1'b0;
		prog_cmd <= '{p, c, ~a};
	endtask
endmodule // pfp_prog_model
`default_nettype wire

// ===== pfp_tb_top.sv
// Self-checking testbench of the program flash protection block.
`timescale 1ns/10ps
`default_nettype none
module pfp_tb_top
	import pfp_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, user_valid = 1'b0, crv = 1'b0, cre = 1'b0;
	logic dv = 1'b0, de = 1'b0, strb_n = 1'b1, se, prog_valid;
	logic ce = 1'b1;
	logic [15:0] da = 16'h0100;
	logic pready, pslverr, user_grant, user_reject, prog_accept;
	logic prog_refuse, flash_go, code_read_allow, data_allow;
	logic serial_download_mode, boot_ready;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] flash_addr, boot_vector;
	pfp_user_req_t user_req = '0;
	pfp_prog_cmd_t prog_cmd;
	pfp_op_t flash_op;
	int err_total = 0, check_count = 0;
	always #25 pclk = ~pclk;
	pfp_top i_pfp_top (.pclk(pclk), .presetn(presetn), .clk_en(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .user_valid(user_valid), .user_req(user_req),
		.user_grant(user_grant), .user_reject(user_reject),
		.prog_valid(prog_valid), .prog_cmd(prog_cmd),
		.prog_accept(prog_accept), .prog_refuse(prog_refuse),
		.flash_go(flash_go), .flash_op(flash_op), .flash_addr(flash_addr),
		.code_read_instruction_valid(crv), .code_read_external(cre),
		.code_read_allow(code_read_allow), .data_valid(dv),
		.data_external(de), .data_addr(da), .data_allow(data_allow),
		.program_store_strobe_n(strb_n),
		.serial_download_mode(serial_download_mode),
		.boot_ready(boot_ready), .boot_vector(boot_vector));
	pfp_prog_model i_pfp_prog_model (.pclk(pclk), .prog_valid(prog_valid),
		.prog_cmd(prog_cmd));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task finish_test;
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; pready !== 1'b1; n++) begin
			if (n == 20) begin
				err_total++;
				finish_test;
			end
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task rst(input logic s, input logic m, input logic [15:0] v);
		@(posedge pclk);
		strb_n <= s;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk({serial_download_mode, boot_ready}, {m, 1'b1});
		chk(boot_vector, v);
	endtask
	task usr(input pfp_op_t o, input logic [15:0] a, input logic g);
		@(posedge pclk);
		user_valid <= 1'b1;
		user_req <= '{o, a};
		@(posedge pclk);
		user_valid <= 1'b0;
		@(negedge pclk);
		chk({flash_go, user_grant, user_reject}, {g, g, !g});
		if (g)
			chk(flash_addr, a);
	endtask
	task prg(input logic p, input pfp_cmd_t c, input logic [15:0] a,
		input logic ok);
		i_pfp_prog_model.send(p, c, a);
		@(negedge pclk);
		chk({prog_accept, prog_refuse}, {ok, !ok});
	endtask
	task acc(input logic d, input logic x, input logic ok);
		@(posedge pclk);
		crv <= !d;
		dv <= d;
		cre <= x;
		de <= x;
		@(posedge pclk);
		crv <= 1'b0;
		dv <= 1'b0;
		@(negedge pclk);
		chk(d ? data_allow : code_read_allow, ok);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		rst(1'b1, 1'b0, PFP_RESET_VECTOR);
		rdc(PFP_STATUS_OFS, 32'h0);
		rdc(PFP_REJECT_OFS, 32'h0);
		rdc(8'h0c, 32'h0);
		chk(se, 1'b1);
		usr(PFP_OP_WRITE, 16'h0100, 1'b0);
		usr(PFP_OP_ERASE, 16'hf000, 1'b0);
		rdc(PFP_REJECT_OFS, 32'h2);
		ce <= 1'b0;
		apb(1'b1, PFP_CTRL_OFS, 32'h1);
		ce <= 1'b1;
		rdc(PFP_CTRL_OFS, 32'h0);
		apb(1'b1, PFP_CTRL_OFS, 32'h1);
		rdc(PFP_STATUS_OFS, 32'h1);
		usr(PFP_OP_ERASE, 16'h0000, 1'b1);
		usr(PFP_OP_WRITE, 16'hdfff, 1'b1);
		usr(PFP_OP_WRITE, 16'he000, 1'b0);
		usr(PFP_OP_ERASE, 16'hf7ff, 1'b0);
		rdc(PFP_REJECT_OFS, 32'h4);
		prg(1'b1, PFP_CMD_PROGRAM, 16'hf000, 1'b1);
		prg(1'b1, PFP_CMD_PROGRAM, 16'hf800, 1'b0);
		prg(1'b0, PFP_CMD_SET_LOCK, 16'h0, 1'b1);
		rdc(PFP_STATUS_OFS, 32'h3);
		prg(1'b1, PFP_CMD_PROGRAM, 16'h0100, 1'b0);
		prg(1'b1, PFP_CMD_READ, 16'h0100, 1'b1);
		acc(1'b0, 1'b1, 1'b1);
		prg(1'b1, PFP_CMD_SET_SECURE, 16'h0, 1'b1);
		prg(1'b1, PFP_CMD_READ, 16'h0100, 1'b0);
		acc(1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b0, 1'b1);
		acc(1'b1, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 1'b1);
		da <= 16'h1000;
		acc(1'b1, 1'b0, 1'b0);
		da <= 16'h0100;
		prg(1'b0, PFP_CMD_SET_SAFE, 16'h0, 1'b1);
		prg(1'b1, PFP_CMD_SET_BOOT, 16'h0, 1'b1);
		rdc(PFP_STATUS_OFS, 32'h1f);
		prg(1'b0, PFP_CMD_CODE_ERASE, 16'h0, 1'b1);
		rdc(PFP_STATUS_OFS, 32'h19);
		acc(1'b0, 1'b1, 1'b1);
		prg(1'b1, PFP_CMD_CODE_ERASE, 16'h0, 1'b1);
		rdc(PFP_STATUS_OFS, 32'h11);
		rst(1'b0, 1'b1, PFP_BOOT_VECTOR);
		rdc(PFP_STATUS_OFS, 32'h30);
		prg(1'b0, PFP_CMD_SET_SAFE, 16'h0, 1'b1);
		rst(1'b0, 1'b0, PFP_BOOT_VECTOR);
		rdc(PFP_STATUS_OFS, 32'h18);
		rdc(PFP_CTRL_OFS, 32'h0);
		finish_test;
	end
endmodule // pfp_tb_top
`default_nettype wire
